// *** pattern_gen_pkg.sv ***
// Purpose: shared constants for the converter test pattern generator
// Assumes: 14-bit samples, byte-wide registers behind a 32-bit wishbone port
// Notes: register offsets are word indices; byte address is four times the index
package pattern_gen_pkg;
  localparam int DATA_W = 14;
  localparam int REG_W = 8;
  localparam int N_DDC = 4;
  localparam int N_USER = 4;
  // register indices
  localparam logic [11:0] IDX_TEST_A = 12'h550;
  localparam logic [11:0] IDX_USER_FIRST = 12'h551;
  localparam logic [11:0] IDX_USER_LAST = 12'h558;
  localparam logic [11:0] IDX_TEST_B = 12'h55f;
  localparam logic [11:0] IDX_FORMAT = 12'h561;
  localparam logic [11:0] IDX_STATUS = 12'h562;
  localparam logic [11:0] IDX_APP_MODE = 12'h200;
  localparam logic [11:0] IDX_DDC0 = 12'h327;
  localparam logic [11:0] IDX_DDC1 = 12'h347;
  localparam logic [11:0] IDX_DDC2 = 12'h367;
  localparam logic [11:0] IDX_DDC3 = 12'h387;
  // test mode register fields
  localparam int TM_CODE_LSB = 0;
  localparam int TM_PN_LONG_RST = 4;
  localparam int TM_PN_SHORT_RST = 5;
  localparam int TM_USER_SINGLE = 7;
  // ddc control fields
  localparam int DDC_TEST_I = 0;
  localparam int DDC_TEST_Q = 2;
  // app mode and format fields
  localparam int APP_DDC_MODE = 0;
  localparam int APP_DDC_EN_LSB = 4;
  localparam int FMT_OFFSET_BIN = 0;
  // reset values
  localparam logic [7:0] TM_RESET = 8'h00;
  localparam logic [7:0] USER_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // pattern codes
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] CODE_MID = 4'h1;
  localparam logic [3:0] CODE_POS_FS = 4'h2;
  localparam logic [3:0] CODE_NEG_FS = 4'h3;
  localparam logic [3:0] CODE_CHECKER = 4'h4;
  localparam logic [3:0] CODE_PN_LONG = 4'h5;
  localparam logic [3:0] CODE_PN_SHORT = 4'h6;
  localparam logic [3:0] CODE_TOGGLE = 4'h7;
  localparam logic [3:0] CODE_USER = 4'h8;
  localparam logic [3:0] CODE_RAMP = 4'hf;
  // fixed words
  localparam logic [13:0] WORD_MID = 14'h0000;
  localparam logic [13:0] WORD_POS_FS = 14'h1fff;
  localparam logic [13:0] WORD_NEG_FS = 14'h2000;
  localparam logic [13:0] WORD_CHECK_EVEN = 14'h1555;
  localparam logic [13:0] WORD_CHECK_ODD = 14'h2aaa;
  localparam logic [13:0] WORD_ZERO = 14'h0000;
  localparam logic [13:0] WORD_ONES = 14'h3fff;
  // generator seeds
  localparam logic [22:0] SEED_PN_LONG = 23'h003aff;
  localparam logic [8:0] SEED_PN_SHORT = 9'h092;
endpackage

// *** pattern_engine.sv ***
// Purpose: one channel's test pattern sequencer
// Assumes: sample_i pulses once per converter sample
// Notes: all sequences restart from their seeds while the code is off
`timescale 1ns/1ps
module pattern_engine
  import pattern_gen_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic sample_i,
  input wire logic [3:0] code_i,
  input wire logic pn_long_rst_i,
  input wire logic pn_short_rst_i,
  input wire logic single_i,
  input wire logic [N_USER*16-1:0] user_i,
  // pattern
  output logic [DATA_W-1:0] pattern_o,
  output logic formatted_o,
  output logic user_done_o
);
  logic [22:0] pn_long;
  logic [8:0] pn_short;
  logic phase;
  logic [2:0] user_idx;
  logic [DATA_W-1:0] ramp;
  logic run;

  // DATA_W (14) lfsr bits per call, each fed back from the two taps
  function automatic logic [22:0] step_long(input logic [22:0] s);
    logic [22:0] r;
    r = s;
    for (int k = 0; k < DATA_W; k++) begin
      r = {r[21:0], r[22] ^ r[17]};
    end
    return r;
  endfunction

  function automatic logic [8:0] step_short(input logic [8:0] s);
    logic [8:0] r;
    r = s;
    for (int k = 0; k < DATA_W; k++) begin
      r = {r[7:0], r[8] ^ r[4]};
    end
    return r;
  endfunction

  assign run = (code_i != CODE_OFF) && sample_i;

  // pseudorandom generators, reset by either reset bit
  always_ff @(posedge clk_i) begin
    if (rst_i || code_i == CODE_OFF || pn_long_rst_i || pn_short_rst_i) begin
      pn_long <= SEED_PN_LONG;
      pn_short <= SEED_PN_SHORT;
    end else if (run) begin
      pn_long <= step_long(pn_long);
      pn_short <= step_short(pn_short);
    end
  end

  // checkerboard / toggle phase and ramp
  always_ff @(posedge clk_i) begin
    if (rst_i || code_i == CODE_OFF) begin
      phase <= 1'b0;
      ramp <= '0;
    end else if (run) begin
      phase <= ~phase;
      ramp <= ramp + DATA_W'(1);
    end
  end

  // user pattern index; index N_USER means the single run is over
  always_ff @(posedge clk_i) begin
    if (rst_i || code_i == CODE_OFF) begin
      user_idx <= '0;
    end else if (run) begin
      if (user_idx == 3'(N_USER - 1)) begin
        user_idx <= single_i ? 3'(N_USER) : 3'd0;
      end else if (user_idx != 3'(N_USER)) begin
        user_idx <= user_idx + 3'd1;
      end
    end
  end

  assign user_done_o = (user_idx == 3'(N_USER));

  // word selection; the fixed levels and checkerboard go through formatting
  always_comb begin
    pattern_o = WORD_ZERO;
    formatted_o = 1'b0;
    unique case (code_i)
      CODE_MID: begin
        pattern_o = WORD_MID;
        formatted_o = 1'b1;
      end
      CODE_POS_FS: begin
        pattern_o = WORD_POS_FS;
        formatted_o = 1'b1;
      end
      CODE_NEG_FS: begin
        pattern_o = WORD_NEG_FS;
        formatted_o = 1'b1;
      end
      CODE_CHECKER: begin
        pattern_o = phase ? WORD_CHECK_ODD : WORD_CHECK_EVEN;
        formatted_o = 1'b1;
      end
      CODE_PN_LONG: pattern_o = pn_long[22:9];
      CODE_PN_SHORT: pattern_o = {pn_short, pn_short[8:4]};
      CODE_TOGGLE: pattern_o = phase ? WORD_ONES : WORD_ZERO;
      CODE_USER: begin
        if (!user_done_o) begin
          pattern_o = user_i[user_idx[1:0]*16+2 +: DATA_W];
        end
      end
      CODE_RAMP: pattern_o = ramp;
      default: pattern_o = WORD_ZERO;
    endcase
  end
endmodule // pattern_engine

// *** adc_test_pattern_gen.sv ***
// Purpose: converter test pattern insertion ahead of output formatting
// Assumes: classic wishbone slave, byte registers in lane 0, one sample per sample_i pulse
// Notes: register offsets and field positions live in the package
`timescale 1ns/1ps
module adc_test_pattern_gen
  import pattern_gen_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [13:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // converter samples
  input wire logic sample_i,
  input wire logic [DATA_W-1:0] adc_a_i,
  input wire logic [DATA_W-1:0] adc_b_i,
  // formatted channel outputs
  output logic [DATA_W-1:0] out_a_o,
  output logic [DATA_W-1:0] out_b_o,
  output logic out_valid_o,
  // downconverter test data
  output logic [N_DDC*DATA_W-1:0] ddc_i_o,
  output logic [N_DDC*DATA_W-1:0] ddc_q_o,
  output logic [N_DDC-1:0] ddc_i_test_o,
  output logic [N_DDC-1:0] ddc_q_test_o
);
  logic [7:0] test_a;
  logic [7:0] test_b;
  logic [7:0] user_reg [2*N_USER];
  logic [7:0] format_reg;
  logic [7:0] app_mode;
  logic [7:0] ddc_ctrl [N_DDC];
  logic [N_USER*16-1:0] user_words;
  logic [DATA_W-1:0] pat_a;
  logic [DATA_W-1:0] pat_b;
  logic fmt_a;
  logic fmt_b;
  logic done_a;
  logic done_b;
  logic [11:0] idx;
  logic req;
  logic wr;
  logic [7:0] next_rdata;
  logic [DATA_W-1:0] next_out_a;
  logic [DATA_W-1:0] next_out_b;

  // offset binary flips the sign bit; raw patterns skip this stage
  function automatic logic [DATA_W-1:0] fmt_word(input logic [DATA_W-1:0] w, input logic apply,
                                                  input logic offset_bin);
    return (apply && offset_bin) ? {~w[DATA_W-1], w[DATA_W-2:0]} : w;
  endfunction

  function automatic logic test_on(input logic [7:0] tm);
    return tm[TM_CODE_LSB +: 4] != CODE_OFF;
  endfunction

  assign idx = adr_i[13:2];
  assign req = cyc_i && stb_i && !ack_o;
  assign wr = req && we_i && sel_i[0];

  // little-endian pairs: even register low byte of a user word
  always_comb begin
    for (int k = 0; k < N_USER; k++) begin
      user_words[k*16 +: 16] = {user_reg[2*k+1], user_reg[2*k]};
    end
  end

  // wishbone ack: one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // test mode registers; the pn reset bits are plain storage, held while set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_a <= TM_RESET;
      test_b <= TM_RESET;
      format_reg <= CTRL_RESET;
      app_mode <= CTRL_RESET;
    end else if (wr) begin
      unique case (idx)
        IDX_TEST_A: test_a <= dat_i[7:0];
        IDX_TEST_B: test_b <= dat_i[7:0];
        IDX_FORMAT: format_reg <= dat_i[7:0];
        IDX_APP_MODE: app_mode <= dat_i[7:0];
        default: ;
      endcase
    end
  end

  // user pattern bytes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < 2*N_USER; k++) begin
        user_reg[k] <= USER_RESET;
      end
    end else if (wr && idx >= IDX_USER_FIRST && idx <= IDX_USER_LAST) begin
      user_reg[3'(idx - IDX_USER_FIRST)] <= dat_i[7:0];
    end
  end

  // downconverter control bytes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < N_DDC; k++) begin
        ddc_ctrl[k] <= CTRL_RESET;
      end
    end else if (wr) begin
      unique case (idx)
        IDX_DDC0: ddc_ctrl[0] <= dat_i[7:0];
        IDX_DDC1: ddc_ctrl[1] <= dat_i[7:0];
        IDX_DDC2: ddc_ctrl[2] <= dat_i[7:0];
        IDX_DDC3: ddc_ctrl[3] <= dat_i[7:0];
        default: ;
      endcase
    end
  end

  // read mux; unmapped indices read zero but still acknowledge
  always_comb begin
    next_rdata = 8'h00;
    unique case (idx)
      IDX_TEST_A: next_rdata = test_a;
      IDX_TEST_B: next_rdata = test_b;
      IDX_FORMAT: next_rdata = format_reg;
      IDX_APP_MODE: next_rdata = app_mode;
      IDX_DDC0: next_rdata = ddc_ctrl[0];
      IDX_DDC1: next_rdata = ddc_ctrl[1];
      IDX_DDC2: next_rdata = ddc_ctrl[2];
      IDX_DDC3: next_rdata = ddc_ctrl[3];
      IDX_STATUS: next_rdata = {4'h0, done_b, done_a, test_on(test_b), test_on(test_a)};
      default: begin
        if (idx >= IDX_USER_FIRST && idx <= IDX_USER_LAST) begin
          next_rdata = user_reg[3'(idx - IDX_USER_FIRST)];
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req && !we_i) begin
      dat_o <= {24'h00_0000, next_rdata};
    end
  end

  // channel engines
  pattern_engine u_engine_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sample_i(sample_i),
    .code_i(test_a[TM_CODE_LSB +: 4]),
    .pn_long_rst_i(test_a[TM_PN_LONG_RST]),
    .pn_short_rst_i(test_a[TM_PN_SHORT_RST]),
    .single_i(test_a[TM_USER_SINGLE]),
    .user_i(user_words),
    .pattern_o(pat_a),
    .formatted_o(fmt_a),
    .user_done_o(done_a)
  );

  pattern_engine u_engine_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sample_i(sample_i),
    .code_i(test_b[TM_CODE_LSB +: 4]),
    .pn_long_rst_i(test_b[TM_PN_LONG_RST]),
    .pn_short_rst_i(test_b[TM_PN_SHORT_RST]),
    .single_i(test_b[TM_USER_SINGLE]),
    .user_i(user_words),
    .pattern_o(pat_b),
    .formatted_o(fmt_b),
    .user_done_o(done_b)
  );

  // pattern replaces the converter word; analog data is never looked at then
  always_comb begin
    next_out_a = test_on(test_a) ? fmt_word(pat_a, fmt_a, format_reg[FMT_OFFSET_BIN])
                                 : fmt_word(adc_a_i, 1'b1, format_reg[FMT_OFFSET_BIN]);
    next_out_b = test_on(test_b) ? fmt_word(pat_b, fmt_b, format_reg[FMT_OFFSET_BIN])
                                 : fmt_word(adc_b_i, 1'b1, format_reg[FMT_OFFSET_BIN]);
  end

  // samples only move with the sample strobe, like the encode clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_a_o <= '0;
      out_b_o <= '0;
      out_valid_o <= 1'b0;
    end else begin
      out_valid_o <= sample_i;
      if (sample_i) begin
        out_a_o <= next_out_a;
        out_b_o <= next_out_b;
      end
    end
  end

  // downconverter insertion; software sets each ddc's enables itself
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ddc_i_o <= '0;
      ddc_q_o <= '0;
      ddc_i_test_o <= '0;
      ddc_q_test_o <= '0;
    end else begin
      for (int k = 0; k < N_DDC; k++) begin
        ddc_i_test_o[k] <= app_mode[APP_DDC_MODE] && app_mode[APP_DDC_EN_LSB+k]
                           && ddc_ctrl[k][DDC_TEST_I];
        if (k == N_DDC - 1) begin
          ddc_q_test_o[k] <= 1'b0;
        end else begin
          ddc_q_test_o[k] <= app_mode[APP_DDC_MODE] && app_mode[APP_DDC_EN_LSB+k]
                             && ddc_ctrl[k][DDC_TEST_Q] && ddc_ctrl[k][DDC_TEST_I];
        end
        if (sample_i) begin
          ddc_i_o[k*DATA_W +: DATA_W] <= pat_a;
          ddc_q_o[k*DATA_W +: DATA_W] <= (k == N_DDC - 1) ? WORD_ZERO : pat_b;
        end
      end
    end
  end

  // checks on the output path
  a_code_off_passes: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_i && !test_on(test_a) && !format_reg[FMT_OFFSET_BIN] |=> out_a_o == $past(adc_a_i))
    else $error("channel a did not pass converter data with test off");
  a_b_off_passes: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_i && !test_on(test_b) && !format_reg[FMT_OFFSET_BIN]
    |=> out_b_o == $past(adc_b_i))
    else $error("channel b did not pass converter data with test off");
  a_pos_full_scale: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_i && test_a[3:0] == CODE_POS_FS && !format_reg[FMT_OFFSET_BIN] |=> out_a_o == WORD_POS_FS)
    else $error("positive full scale word wrong");
  a_neg_full_scale: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_i && test_a[3:0] == CODE_NEG_FS && !format_reg[FMT_OFFSET_BIN]
    |=> out_a_o == WORD_NEG_FS)
    else $error("negative full scale word wrong");
  a_mid_scale: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_i && test_a[3:0] == CODE_MID && !format_reg[FMT_OFFSET_BIN]
    |=> out_a_o == WORD_MID)
    else $error("midscale word wrong");
  a_raw_unformatted: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_i && test_on(test_a) && !fmt_a
    |=> out_a_o == $past(pat_a))
    else $error("raw pattern went through formatting");
  a_formatted_flip: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_i && test_on(test_a) && fmt_a && format_reg[FMT_OFFSET_BIN]
    |=> out_a_o == ($past(pat_a) ^ {1'b1, {(DATA_W-1){1'b0}}}))
    else $error("formatted pattern missed offset binary");
  a_valid_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_i
    |=> out_valid_o)
    else $error("sample not marked valid");
  a_out_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !sample_i
    |=> !out_valid_o && $stable(out_a_o) && $stable(out_b_o))
    else $error("outputs moved without a sample");

  // sequence checks; a test register write in the same cycle legally moves the word
  a_checker_alt: assert property (@(posedge clk_i) disable iff (rst_i)
    test_a[3:0] == CODE_CHECKER && $stable(test_a) && sample_i && pat_a == WORD_CHECK_EVEN
    |=> pat_a == WORD_CHECK_ODD)
    else $error("checkerboard did not alternate");
  a_toggle_alt: assert property (@(posedge clk_i) disable iff (rst_i)
    test_a[3:0] == CODE_TOGGLE && $stable(test_a) && sample_i |=> pat_a == ~$past(pat_a))
    else $error("word toggle did not invert");
  a_b_toggle_alt: assert property (@(posedge clk_i) disable iff (rst_i)
    test_b[3:0] == CODE_TOGGLE && $stable(test_b) && sample_i
    |=> pat_b == ~$past(pat_b))
    else $error("channel b word toggle did not invert");
  a_ramp_step: assert property (@(posedge clk_i) disable iff (rst_i)
    test_a[3:0] == CODE_RAMP && $stable(test_a) && sample_i |=> pat_a == DATA_W'($past(pat_a) + 1'b1))
    else $error("ramp did not step by one");
  a_ramp_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    test_a[3:0] == CODE_RAMP && $stable(test_a) && !sample_i && !(wr && idx == IDX_TEST_A) |=> $stable(pat_a))
    else $error("ramp moved without a sample");
  a_pn_long_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    test_a[3:0] == CODE_PN_LONG && $stable(test_a) && !sample_i && !(wr && idx == IDX_TEST_A)
    |=> $stable(pat_a))
    else $error("long pn moved without a sample");
  a_pn_short_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    test_a[3:0] == CODE_PN_SHORT && $stable(test_a) && !sample_i && !(wr && idx == IDX_TEST_A)
    |=> $stable(pat_a))
    else $error("short pn moved without a sample");
  a_pn_reseed: assert property (@(posedge clk_i) disable iff (rst_i)
    test_a[3:0] == CODE_PN_LONG && test_a[TM_PN_LONG_RST] |=> pat_a == SEED_PN_LONG[22:9])
    else $error("long pn not reseeded");
  a_pn_short_seed: assert property (@(posedge clk_i) disable iff (rst_i)
    test_a[3:0] == CODE_PN_SHORT && test_a[TM_PN_SHORT_RST]
    |=> pat_a == {SEED_PN_SHORT, SEED_PN_SHORT[8:4]})
    else $error("short pn not reseeded");
  a_user_single: assert property (@(posedge clk_i) disable iff (rst_i)
    test_a[3:0] == CODE_USER && test_a[TM_USER_SINGLE] && done_a |-> pat_a == WORD_ZERO)
    else $error("single user run not followed by zeros");

  // downconverter checks
  a_ddc_i_source: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_i |=> ddc_i_o[DATA_W-1:0] == $past(pat_a) && ddc_q_o[DATA_W-1:0] == $past(pat_b))
    else $error("ddc i/q not fed from channels a/b");
  a_ddc3_no_q: assert property (@(posedge clk_i) disable iff (rst_i)
    !ddc_q_test_o[N_DDC-1] && ddc_q_o[N_DDC*DATA_W-1 -: DATA_W] == WORD_ZERO)
    else $error("fourth ddc carried a q pattern");
  a_ddc3_i_source: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_i
    |=> ddc_i_o[N_DDC*DATA_W-1 -: DATA_W] == $past(pat_a))
    else $error("fourth ddc i not fed from channel a");
  a_ddc3_i_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    app_mode[APP_DDC_MODE] && app_mode[APP_DDC_EN_LSB+N_DDC-1] && ddc_ctrl[N_DDC-1][DDC_TEST_I]
    |=> ddc_i_test_o[N_DDC-1])
    else $error("fourth ddc i test not enabled by its bit");
  a_ddc0_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !(app_mode[APP_DDC_MODE] && app_mode[APP_DDC_EN_LSB] && ddc_ctrl[0][DDC_TEST_I])
    |=> !ddc_i_test_o[0] && !ddc_q_test_o[0])
    else $error("ddc 0 test insertion without its enables");

  // bus checks
  a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("wishbone ack not a single cycle");
  a_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cyc_i && stb_i) |=> !ack_o)
    else $error("wishbone ack without a request");
endmodule // adc_test_pattern_gen

// *** output_sink.sv ***
// Purpose: downstream formatter stand-in that takes every output sample
// Assumes: valid_i marks one sample per high cycle
// Notes: no backpressure, the real output stage cannot stall either
`timescale 1ns/1ps
module output_sink
  import pattern_gen_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // sample stream
  input wire logic valid_i,
  input wire logic [DATA_W-1:0] a_i,
  input wire logic [DATA_W-1:0] b_i,
  // observation
  output logic [31:0] count_o,
  output logic [2*DATA_W-1:0] last_o
);
  // count every sample handed over and keep the last one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= 32'h0;
      last_o <= '0;
    end else if (valid_i) begin
      count_o <= count_o + 32'h1;
      last_o <= {a_i, b_i};
    end
  end
endmodule // output_sink

// *** tb_top.sv ***
// Purpose: self-checking bench for the converter test pattern generator
// Assumes: one sample per sample_i high cycle, registers behind classic wishbone
// Notes: pn words are checked for restart and reseed, not for exact values
`timescale 1ns/1ps
module tb_top;
  import pattern_gen_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, sample_i, out_valid_o, fmt, single;
  logic [13:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd, seen;
  logic [DATA_W-1:0] adc_a_i, adc_b_i, out_a_o, out_b_o;
  logic [N_DDC*DATA_W-1:0] ddc_i_o, ddc_q_o;
  logic [N_DDC-1:0] ddc_i_test_o, ddc_q_test_o;
  logic [DATA_W-1:0] user_w [4];
  logic [DATA_W-1:0] cap [6];
  logic [3:0] codes [5] = '{CODE_MID, CODE_POS_FS, CODE_NEG_FS, CODE_CHECKER, CODE_TOGGLE};
  logic [7:0] lo, hi;
  logic [2*DATA_W-1:0] last;
  int err_total, samples_checked, cycles, sent;

  adc_test_pattern_gen DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .sample_i, .adc_a_i, .adc_b_i, .out_a_o, .out_b_o, .out_valid_o, .ddc_i_o, .ddc_q_o, .ddc_i_test_o,
    .ddc_q_test_o);
  output_sink sink (.clk_i, .rst_i, .valid_i(out_valid_o), .a_i(out_a_o), .b_i(out_b_o), .count_o(seen),
    .last_o(last));

  // 125 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // hang guard, ramp wrap alone takes about 16k cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      test_done();
    end
  end

  task test_done;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // classic single cycle, held until ack is sampled high
  task wb(input logic w, input logic [11:0] idx, input logic [7:0] d, input logic s0);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= {3'b000, s0};
    dat_i <= {24'h0, d};
    // no cycle count assumed; only the hang guard ends a stalled access
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task rchk(input logic [11:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00, 1'b1);
    cmp("register", {24'h0, exp}, rd);
  endtask

  task codes_set(input logic [7:0] a, input logic [7:0] b);
    wb(1'b1, IDX_TEST_A, a, 1'b1);
    wb(1'b1, IDX_TEST_B, b, 1'b1);
  endtask

  function automatic logic [13:0] av(input int k);
    return 14'(k * 37 + 291);
  endfunction

  // expected word of sample k; pn codes are handled by capture instead
  function automatic logic [13:0] expw(input logic [3:0] c, input int k, input logic [13:0] adc);
    logic [13:0] w;
    case (c)
      CODE_OFF: w = adc;
      CODE_MID: w = WORD_MID;
      CODE_POS_FS: w = WORD_POS_FS;
      CODE_NEG_FS: w = WORD_NEG_FS;
      CODE_CHECKER: w = k[0] ? WORD_CHECK_ODD : WORD_CHECK_EVEN;
      CODE_TOGGLE: w = k[0] ? WORD_ONES : WORD_ZERO;
      CODE_USER: w = (single && k > 3) ? WORD_ZERO : user_w[k % 4];
      CODE_RAMP: w = k[13:0];
      default: w = 14'h0000;
    endcase
    if (fmt && c < 4'h5) w[13] = ~w[13];
    return w;
  endfunction

  // back-to-back samples k0..k0+n-1; pn 1 stores channel a, pn 2 compares with the store
  task run(input logic [3:0] ca, input logic [3:0] cb, input int k0, input int n, input int pn);
    int k;
    @(posedge clk_i);
    sample_i <= 1'b1;
    adc_a_i <= av(k0);
    adc_b_i <= ~av(k0);
    for (k = k0; k < k0 + n; k++) begin
      @(posedge clk_i);
      adc_a_i <= av(k + 1);
      adc_b_i <= ~av(k + 1);
      if (k == k0 + n - 1) sample_i <= 1'b0;
      sent++;
      #1;
      if (pn == 1) cap[k] = out_a_o;
      else if (pn == 2) cmp("pn", 32'(cap[k]), 32'(out_a_o));
      else cmp("out_a", 32'(expw(ca, k, av(k))), 32'(out_a_o));
      if (pn == 0) cmp("out_b", 32'(expw(cb, k, ~av(k))), 32'(out_b_o));
      if (ca > 4'h4 && pn == 0) cmp("ddc_i", 32'(expw(ca, k, 14'h0)), 32'(ddc_i_o[13:0]));
      if (ca > 4'h4 && pn == 0) cmp("ddc3_i", 32'(expw(ca, k, 14'h0)), 32'(ddc_i_o[55:42]));
      if (cb > 4'h4) cmp("ddc_q", 32'(expw(cb, k, 14'h0)), 32'(ddc_q_o[13:0]));
      cmp("ddc3_q", 32'h0, 32'(ddc_q_o[55:42]));
    end
  endtask

  task pn_check(input logic [3:0] c, input logic [7:0] reseed);
    codes_set(8'h00, 8'h00);
    codes_set({4'h0, c}, 8'h00);
    run(c, CODE_OFF, 0, 3, 1);
    repeat (3) @(posedge clk_i);
    run(c, CODE_OFF, 3, 3, 1);
    cmp("pn moves", 32'h1, 32'(cap[0] != cap[1]));
    codes_set(reseed | {4'h0, c}, 8'h00);
    codes_set({4'h0, c}, 8'h00);
    run(c, CODE_OFF, 0, 6, 2);
  endtask

  initial begin
    {rst_i, cyc_i, stb_i, we_i, sample_i, fmt, single} = 7'b1000000;
    {adr_i, sel_i, dat_i, adc_a_i, adc_b_i} = '0;
    {err_total, samples_checked, cycles, sent} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped and masked accesses
    rchk(IDX_TEST_A, TM_RESET);
    rchk(IDX_USER_FIRST, USER_RESET);
    rchk(IDX_DDC0, CTRL_RESET);
    rchk(12'h100, 8'h00);
    wb(1'b1, IDX_TEST_A, 8'h07, 1'b0);
    rchk(IDX_TEST_A, 8'h00);
    run(CODE_OFF, CODE_OFF, 0, 3, 0);
    // fixed and alternating codes in both output formats
    for (int f = 0; f < 2; f++) begin
      fmt = f[0];
      wb(1'b1, IDX_FORMAT, {7'h0, fmt}, 1'b1);
      for (int i = 0; i < 5; i++) begin
        codes_set(8'h00, 8'h00);
        codes_set({4'h0, codes[i]}, {4'h0, codes[4 - i]});
        run(codes[i], codes[4 - i], 0, 3, 0);
      end
    end
    fmt = 1'b0;
    wb(1'b1, IDX_FORMAT, 8'h00, 1'b1);
    wb(1'b1, IDX_STATUS, 8'h00, 1'b1);
    rchk(IDX_STATUS, 8'h03);
    // sequences hold still between samples
    codes_set(8'h00, 8'h00);
    codes_set({4'h0, CODE_CHECKER}, {4'h0, CODE_TOGGLE});
    run(CODE_CHECKER, CODE_TOGGLE, 0, 3, 0);
    repeat (5) @(posedge clk_i);
    run(CODE_CHECKER, CODE_TOGGLE, 3, 2, 0);
    // user words, repeat then single
    for (int n = 0; n < 4; n++) begin
      lo = 8'(n * 53 + 28);
      hi = 8'(n * 75 + 145);
      user_w[n] = {hi, lo[7:2]};
      wb(1'b1, IDX_USER_FIRST + 12'(2 * n), lo, 1'b1);
      wb(1'b1, IDX_USER_FIRST + 12'(2 * n + 1), hi, 1'b1);
    end
    rchk(IDX_USER_LAST, hi);
    codes_set(8'h00, 8'h00);
    codes_set({4'h0, CODE_USER}, {4'h0, CODE_USER});
    run(CODE_USER, CODE_USER, 0, 6, 0);
    single = 1'b1;
    codes_set(8'h00, 8'h00);
    codes_set({4'h8, CODE_USER}, {4'h8, CODE_USER});
    run(CODE_USER, CODE_USER, 0, 6, 0);
    rchk(IDX_STATUS, 8'h0f);
    // ramp through its wrap
    codes_set(8'h00, 8'h00);
    codes_set({4'h0, CODE_RAMP}, 8'h00);
    run(CODE_RAMP, CODE_OFF, 0, 16386, 0);
    // downconverter insertion, software enables both test bits
    wb(1'b1, IDX_APP_MODE, 8'hf1, 1'b1);
    wb(1'b1, IDX_DDC0, 8'h05, 1'b1);
    wb(1'b1, IDX_DDC1, 8'h05, 1'b1);
    wb(1'b1, IDX_DDC2, 8'h05, 1'b1);
    wb(1'b1, IDX_DDC3, 8'h05, 1'b1);
    codes_set(8'h00, 8'h00);
    codes_set({4'h0, CODE_RAMP}, {4'h0, CODE_TOGGLE});
    repeat (2) @(posedge clk_i);
    #1;
    cmp("ddc_i_test", 32'hf, 32'(ddc_i_test_o));
    cmp("ddc_q_test", 32'h7, 32'(ddc_q_test_o));
    wb(1'b1, IDX_DDC1, 8'h04, 1'b1);
    repeat (2) @(posedge clk_i);
    #1;
    cmp("ddc_i_test", 32'hd, 32'(ddc_i_test_o));
    cmp("ddc_q_test", 32'h5, 32'(ddc_q_test_o));
    run(CODE_RAMP, CODE_TOGGLE, 0, 4, 0);
    // both generators, restart from seed by each reseed bit
    pn_check(CODE_PN_LONG, 8'h10);
    pn_check(CODE_PN_SHORT, 8'h20);
    repeat (3) @(posedge clk_i);
    cmp("sample count", 32'(sent), seen);
    cmp("sink last", 32'({cap[5], ~av(5)}), 32'(last));
    test_done();
  end
endmodule // tb_top
